/* hdl/pmbcfg_regs.vh */
`ifndef PMBCFG_REGS_VH
`define PMBCFG_REGS_VH

// Command codes, used as register offsets.
`define PMBCFG_CMD_CML 8'h7e
`define PMBCFG_CMD_VIN 8'h88
`define PMBCFG_CMD_VOUT 8'h8b
`define PMBCFG_CMD_IOUT 8'h8c
`define PMBCFG_CMD_TEMP 8'h8d
`define PMBCFG_CMD_TYPE 8'hd0
`define PMBCFG_CMD_VOUT_GAIN 8'hd1
`define PMBCFG_CMD_VOUT_OFS 8'hd2
`define PMBCFG_CMD_VIN_GAIN 8'hd3
`define PMBCFG_CMD_VIN_OFS 8'hd4
`define PMBCFG_CMD_IOUT_GAIN 8'hd6
`define PMBCFG_CMD_IOUT_OFS 8'hd7
`define PMBCFG_CMD_FW_REV 8'hdb
`define PMBCFG_CMD_ARA_CFG 8'he0

// Field positions.
`define PMBCFG_CML_BAD_CMD 7
`define PMBCFG_CML_BAD_DATA 6
`define PMBCFG_CML_PEC 5
`define PMBCFG_TYPE_WPE 1
`define PMBCFG_TYPE_NAME_LSB 2
`define PMBCFG_ARA_EN_BIT 4
`define PMBCFG_EXP_MSB 15
`define PMBCFG_EXP_LSB 11

// Values, limits and reset values.
`define PMBCFG_GAIN_MIN 16'h1999
`define PMBCFG_GAIN_MAX 16'h2666
`define PMBCFG_GAIN_RESET 16'h2000
`define PMBCFG_WPE_RESET 1'b1
`define PMBCFG_ARA_EN_RESET 1'b0
`define PMBCFG_MAP_RESET 4'h0
`define PMBCFG_EXP_VOUT_OFS 5'h14
`define PMBCFG_EXP_VIN_OFS 5'h1d
`define PMBCFG_EXP_IOUT_OFS 5'h1c
`define PMBCFG_VOUT_OFS_RESET 16'ha000
`define PMBCFG_VIN_OFS_RESET 16'he800
`define PMBCFG_IOUT_OFS_RESET 16'he000
`define PMBCFG_MAP_SEC_PG 4'h0
`define PMBCFG_MAP_TRIM_PG 4'h1
`define PMBCFG_MAP_TRIM_SEC 4'h2
`define PMBCFG_ALERT_RESP_ADDR 7'h0c
`define PMBCFG_CRC_POLY 8'h07

`endif

/* hdl/pmbcfg_bank.v */
`timescale 1ns/1ps
`include "pmbcfg_regs.vh"

module pmbcfg_bank #(
	// Name code value is arbitrary.
	parameter [5:0] MODULE_NAME = 6'h2a,
	// Revision value is arbitrary.
	parameter [7:0] FIRMWARE_REV = 8'h10,
	parameter LOAD_SHARE = 0
) (
	// Clock and reset
	input wire clk,
	input wire rst_b,
	// Serial bus pins
	input wire scl_in,
	input wire sda_in,
	output wire sda_out,
	output reg sda_oe,
	// Address strap and alert state
	input wire [6:0] bus_addr_strap,
	input wire alert_asserted,
	// Measurements
	input wire [15:0] meas_vin,
	input wire [15:0] meas_vout,
	input wire [15:0] meas_iout,
	input wire [15:0] meas_temp,
	// Calibration values
	output reg [15:0] vout_readback_gain_cal,
	output reg [15:0] vout_readback_offset_cal,
	output reg [15:0] vin_readback_gain_cal,
	output reg [15:0] vin_readback_offset_cal,
	output reg [15:0] iout_gain_cal,
	output reg [15:0] iout_offset_cal,
	// Configuration state
	output reg write_protect_enable,
	output wire ara_active,
	output wire pin_one_is_trim,
	output wire pin_one_is_sec_enable,
	output wire pin_two_is_power_good,
	output wire pin_two_is_sec_enable
);

	localparam [3:0] S_IDLE = 4'h1;
	localparam [3:0] S_ADDR = 4'h2;
	localparam [3:0] S_WRITE = 4'h4;
	localparam [3:0] S_READ = 4'h8;

	reg scl_s1, scl_s2, scl_d;
	reg sda_s1, sda_s2, sda_d;
	reg [6:0] strap_s1, strap_s2;
	reg [3:0] state;
	reg [3:0] bitcnt;
	reg [7:0] shreg;
	reg [7:0] txsh;
	reg ack_go, ack_done, rw, ara_sel;
	reg [2:0] nbytes;
	reg [1:0] rd_idx;
	reg [7:0] cmd, d0, d1, crc;
	reg [2:0] cml;
	reg ara_en;
	reg [3:0] pin_map;

	reg [2:0] next_cml, set_bits, clr_bits;
	reg next_wpe, next_ara_en;
	reg [3:0] next_pin_map;
	reg [15:0] next_vg, next_vo, next_ig, next_io, next_cg, next_co;
	reg [15:0] rd_word;
	reg [7:0] tx_byte;
	reg [1:0] wlen;

	wire scl_rise = scl_s2 & ~scl_d;
	wire scl_fall = ~scl_s2 & scl_d;
	wire start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
	wire stop_det = scl_s2 & scl_d & ~sda_d & sda_s2;
	wire [7:0] rx_byte = {shreg[6:0], sda_s2};
	wire byte_end = scl_rise & (bitcnt == 4'd7);
	wire active = (state == S_ADDR) | (state == S_WRITE) | (state == S_READ);
	wire [15:0] word = {d1, d0};
	wire commit = stop_det & (state == S_WRITE) & (nbytes > 3'd1);
	wire bad_cmd_ev;
	wire addr_hit;

	assign sda_out = 1'b0;
	assign ara_active = ara_en & alert_asserted;
	// Alert response address is read-only, so only a read header is taken there.
	assign addr_hit = ara_active ?
		(rx_byte[7:1] == `PMBCFG_ALERT_RESP_ADDR) & rx_byte[0] :
		(rx_byte[7:1] == strap_s2);
	assign pin_one_is_sec_enable = (pin_map == `PMBCFG_MAP_SEC_PG);
	assign pin_one_is_trim = (pin_map == `PMBCFG_MAP_TRIM_PG) |
		(pin_map == `PMBCFG_MAP_TRIM_SEC);
	assign pin_two_is_power_good = (pin_map == `PMBCFG_MAP_SEC_PG) |
		(pin_map == `PMBCFG_MAP_TRIM_PG);
	assign pin_two_is_sec_enable = (pin_map == `PMBCFG_MAP_TRIM_SEC);

	function [1:0] cmd_len;
		input [7:0] c;
		begin
			case (c)
				`PMBCFG_CMD_CML, `PMBCFG_CMD_FW_REV, `PMBCFG_CMD_ARA_CFG: cmd_len = 2'd1;
				`PMBCFG_CMD_VIN, `PMBCFG_CMD_VOUT, `PMBCFG_CMD_IOUT, `PMBCFG_CMD_TEMP,
				`PMBCFG_CMD_TYPE, `PMBCFG_CMD_VOUT_GAIN, `PMBCFG_CMD_VOUT_OFS,
				`PMBCFG_CMD_VIN_GAIN, `PMBCFG_CMD_VIN_OFS, `PMBCFG_CMD_IOUT_GAIN,
				`PMBCFG_CMD_IOUT_OFS: cmd_len = 2'd2;
				default: cmd_len = 2'd0;
			endcase
		end
	endfunction

	function cmd_is_cal;
		input [7:0] c;
		begin
			cmd_is_cal = (c == `PMBCFG_CMD_VOUT_GAIN) | (c == `PMBCFG_CMD_VOUT_OFS) |
				(c == `PMBCFG_CMD_VIN_GAIN) | (c == `PMBCFG_CMD_VIN_OFS) |
				(c == `PMBCFG_CMD_IOUT_GAIN) | (c == `PMBCFG_CMD_IOUT_OFS);
		end
	endfunction

	function [7:0] crc8;
		input [7:0] c;
		input [7:0] b;
		integer i;
		reg [7:0] x;
		begin
			x = c ^ b;
			for (i = 0; i < 8; i = i + 1) begin
				x = x[7] ? ({x[6:0], 1'b0} ^ `PMBCFG_CRC_POLY) : {x[6:0], 1'b0};
			end
			crc8 = x;
		end
	endfunction

	function gain_ok;
		input [15:0] g;
		begin
			gain_ok = (g >= `PMBCFG_GAIN_MIN) && (g <= `PMBCFG_GAIN_MAX);
		end
	endfunction

	function map_ok;
		input [3:0] m;
		begin
			if (LOAD_SHARE != 0) begin
				map_ok = (m == `PMBCFG_MAP_SEC_PG);
			end else begin
				map_ok = (m == `PMBCFG_MAP_SEC_PG) | (m == `PMBCFG_MAP_TRIM_PG) |
					(m == `PMBCFG_MAP_TRIM_SEC);
			end
		end
	endfunction

	assign bad_cmd_ev = byte_end & (state == S_WRITE) & (nbytes == 3'd0) &
		(cmd_len(rx_byte) == 2'd0);

	// Readback mux; reserved bits read as zero.
	always @* begin
		rd_word = 16'hffff;
		case (cmd)
			`PMBCFG_CMD_CML: rd_word = {8'h00, cml, 5'h00};
			`PMBCFG_CMD_VIN: rd_word = meas_vin;
			`PMBCFG_CMD_VOUT: rd_word = meas_vout;
			`PMBCFG_CMD_IOUT: rd_word = meas_iout;
			`PMBCFG_CMD_TEMP: rd_word = meas_temp;
			`PMBCFG_CMD_TYPE: rd_word = {8'h00, MODULE_NAME, write_protect_enable, 1'b0};
			`PMBCFG_CMD_VOUT_GAIN: rd_word = vout_readback_gain_cal;
			`PMBCFG_CMD_VOUT_OFS: rd_word = vout_readback_offset_cal;
			`PMBCFG_CMD_VIN_GAIN: rd_word = vin_readback_gain_cal;
			`PMBCFG_CMD_VIN_OFS: rd_word = vin_readback_offset_cal;
			`PMBCFG_CMD_IOUT_GAIN: rd_word = iout_gain_cal;
			`PMBCFG_CMD_IOUT_OFS: rd_word = iout_offset_cal;
			`PMBCFG_CMD_FW_REV: rd_word = {8'h00, FIRMWARE_REV};
			`PMBCFG_CMD_ARA_CFG: rd_word = {11'h000, ara_en, pin_map};
			default: rd_word = 16'hffff;
		endcase
	end

	// Words go out low byte first; bytes past the register's length read 0xff.
	always @* begin
		tx_byte = 8'hff;
		if (ara_sel) begin
			tx_byte = (rd_idx == 2'd0) ? {strap_s2, 1'b0} : 8'hff;
		end else if (rd_idx == 2'd0) begin
			tx_byte = rd_word[7:0];
		end else if (rd_idx == 2'd1 && cmd_len(cmd) == 2'd2) begin
			tx_byte = rd_word[15:8];
		end
	end

	// Write commit at stop. One fault is reported per transaction, checked in order.
	always @* begin
		wlen = cmd_len(cmd);
		set_bits = 3'h0;
		clr_bits = 3'h0;
		next_wpe = write_protect_enable;
		next_ara_en = ara_en;
		next_pin_map = pin_map;
		next_vg = vout_readback_gain_cal;
		next_vo = vout_readback_offset_cal;
		next_ig = vin_readback_gain_cal;
		next_io = vin_readback_offset_cal;
		next_cg = iout_gain_cal;
		next_co = iout_offset_cal;
		if (commit && wlen != 2'd0) begin
			if (!(cmd == `PMBCFG_CMD_CML || cmd == `PMBCFG_CMD_TYPE ||
				cmd == `PMBCFG_CMD_ARA_CFG || cmd_is_cal(cmd))) begin
				set_bits[2] = 1'b1;
			end else if (nbytes != {1'b0, wlen} + 3'd1 &&
				nbytes != {1'b0, wlen} + 3'd2) begin
				set_bits[1] = 1'b1;
			end else if (nbytes == {1'b0, wlen} + 3'd2 && crc != 8'h00) begin
				set_bits[0] = 1'b1;
			end else if (write_protect_enable && cmd_is_cal(cmd)) begin
				set_bits[1] = 1'b1;
			end else begin
				case (cmd)
					`PMBCFG_CMD_CML: clr_bits = d0[7:5];
					`PMBCFG_CMD_TYPE: next_wpe = d0[`PMBCFG_TYPE_WPE];
					`PMBCFG_CMD_VOUT_GAIN: begin
						if (gain_ok(word)) next_vg = word;
						else set_bits[1] = 1'b1;
					end
					`PMBCFG_CMD_VIN_GAIN: begin
						if (gain_ok(word)) next_ig = word;
						else set_bits[1] = 1'b1;
					end
					`PMBCFG_CMD_IOUT_GAIN: begin
						if (gain_ok(word)) next_cg = word;
						else set_bits[1] = 1'b1;
					end
					`PMBCFG_CMD_VOUT_OFS: begin
						if (word[`PMBCFG_EXP_MSB:`PMBCFG_EXP_LSB] == `PMBCFG_EXP_VOUT_OFS)
							next_vo = word;
						else set_bits[1] = 1'b1;
					end
					`PMBCFG_CMD_VIN_OFS: begin
						if (word[`PMBCFG_EXP_MSB:`PMBCFG_EXP_LSB] == `PMBCFG_EXP_VIN_OFS)
							next_io = word;
						else set_bits[1] = 1'b1;
					end
					`PMBCFG_CMD_IOUT_OFS: begin
						if (word[`PMBCFG_EXP_MSB:`PMBCFG_EXP_LSB] == `PMBCFG_EXP_IOUT_OFS)
							next_co = word;
						else set_bits[1] = 1'b1;
					end
					`PMBCFG_CMD_ARA_CFG: begin
						if (map_ok(d0[3:0])) begin
							next_ara_en = d0[`PMBCFG_ARA_EN_BIT];
							next_pin_map = d0[3:0];
						end else begin
							set_bits[1] = 1'b1;
						end
					end
					default: set_bits[2] = 1'b1;
				endcase
			end
		end
		// A fault raised in the clearing cycle survives the clear.
		next_cml = (cml & ~clr_bits) | set_bits | {bad_cmd_ev, 2'b00};
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_d <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_d <= 1'b1;
			strap_s1 <= 7'h00;
			strap_s2 <= 7'h00;
			state <= S_IDLE;
			bitcnt <= 4'h0;
			shreg <= 8'h00;
			txsh <= 8'h00;
			ack_go <= 1'b0;
			ack_done <= 1'b0;
			rw <= 1'b0;
			ara_sel <= 1'b0;
			nbytes <= 3'h0;
			rd_idx <= 2'h0;
			cmd <= 8'h00;
			d0 <= 8'h00;
			d1 <= 8'h00;
			crc <= 8'h00;
			sda_oe <= 1'b0;
			cml <= 3'h0;
			write_protect_enable <= `PMBCFG_WPE_RESET;
			ara_en <= `PMBCFG_ARA_EN_RESET;
			pin_map <= `PMBCFG_MAP_RESET;
			vout_readback_gain_cal <= `PMBCFG_GAIN_RESET;
			vout_readback_offset_cal <= `PMBCFG_VOUT_OFS_RESET;
			vin_readback_gain_cal <= `PMBCFG_GAIN_RESET;
			vin_readback_offset_cal <= `PMBCFG_VIN_OFS_RESET;
			iout_gain_cal <= `PMBCFG_GAIN_RESET;
			iout_offset_cal <= `PMBCFG_IOUT_OFS_RESET;
		end else begin
			scl_s1 <= scl_in;
			scl_s2 <= scl_s1;
			scl_d <= scl_s2;
			sda_s1 <= sda_in;
			sda_s2 <= sda_s1;
			sda_d <= sda_s2;
			strap_s1 <= bus_addr_strap;
			strap_s2 <= strap_s1;
			cml <= next_cml;
			write_protect_enable <= next_wpe;
			ara_en <= next_ara_en;
			pin_map <= next_pin_map;
			vout_readback_gain_cal <= next_vg;
			vout_readback_offset_cal <= next_vo;
			vin_readback_gain_cal <= next_ig;
			vin_readback_offset_cal <= next_io;
			iout_gain_cal <= next_cg;
			iout_offset_cal <= next_co;
			if (start_det) begin
				state <= S_ADDR;
				bitcnt <= 4'h0;
				ack_done <= 1'b0;
				ack_go <= 1'b0;
				rd_idx <= 2'h0;
				sda_oe <= 1'b0;
			end else if (stop_det) begin
				state <= S_IDLE;
				sda_oe <= 1'b0;
			end else if (scl_rise && active) begin
				if (bitcnt == 4'd8) begin
					bitcnt <= 4'h0;
					ack_done <= 1'b1;
					// A not-acknowledge from the host ends the read.
					if (state == S_READ && sda_s2) state <= S_IDLE;
				end else begin
					bitcnt <= bitcnt + 4'd1;
					shreg <= rx_byte;
					if (byte_end && state == S_ADDR) begin
						if (addr_hit) begin
							rw <= rx_byte[0];
							ara_sel <= ara_active;
							ack_go <= 1'b1;
							if (!rx_byte[0]) begin
								nbytes <= 3'h0;
								crc <= crc8(8'h00, rx_byte);
							end
						end else begin
							state <= S_IDLE;
						end
					end else if (byte_end && state == S_WRITE) begin
						ack_go <= 1'b1;
						crc <= crc8(crc, rx_byte);
						if (nbytes != 3'd7) nbytes <= nbytes + 3'd1;
						if (nbytes == 3'd0) cmd <= rx_byte;
						if (nbytes == 3'd1) d0 <= rx_byte;
						if (nbytes == 3'd2) d1 <= rx_byte;
					end
				end
			end else if (scl_fall && active) begin
				if (bitcnt == 4'd8) begin
					sda_oe <= (state == S_READ) ? 1'b0 : ack_go;
				end else if (bitcnt == 4'd0 && ack_done) begin
					ack_done <= 1'b0;
					ack_go <= 1'b0;
					if (state == S_WRITE || (state == S_ADDR && !rw)) begin
						state <= S_WRITE;
						sda_oe <= 1'b0;
					end else begin
						state <= S_READ;
						txsh <= tx_byte;
						sda_oe <= ~tx_byte[7];
						if (rd_idx != 2'd3) rd_idx <= rd_idx + 2'd1;
					end
				end else if (state == S_READ) begin
					txsh <= {txsh[6:0], 1'b0};
					sda_oe <= ~txsh[6];
				end
			end
		end
	end

endmodule // pmbcfg_bank

/* tb/pmbcfg_chk_assertions.sv */
`timescale 1ns/1ps
module pmbcfg_chk (
	// Clock and reset
	input wire clk,
	input wire rst_b,
	// Bus pins
	input wire scl_in,
	input wire sda_in,
	input wire sda_oe,
	// Alert
	input wire alert_asserted,
	input wire ara_active,
	// Calibration and lock
	input wire write_protect_enable,
	input wire [15:0] vout_readback_gain_cal,
	input wire [15:0] vin_readback_gain_cal,
	input wire [15:0] iout_gain_cal,
	input wire [15:0] vout_readback_offset_cal,
	input wire [15:0] vin_readback_offset_cal,
	input wire [15:0] iout_offset_cal,
	// Pin functions
	input wire pin_one_is_trim,
	input wire pin_one_is_sec_enable,
	input wire pin_two_is_power_good,
	input wire pin_two_is_sec_enable
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire [95:0] cal = {vout_readback_gain_cal, vin_readback_gain_cal, iout_gain_cal,
		vout_readback_offset_cal, vin_readback_offset_cal, iout_offset_cal};
	function automatic logic in_range(input [15:0] g);
		return g >= 16'h1999 && g <= 16'h2666;
	endfunction
	ara_gate_a: assert property (ara_active |-> alert_asserted)
		else $error("alert answer mode without alert");
	pin_one_a: assert property ($onehot({pin_one_is_trim, pin_one_is_sec_enable}))
		else $error("first pin function not unique");
	pin_two_a: assert property ($onehot({pin_two_is_power_good, pin_two_is_sec_enable}))
		else $error("second pin function not unique");
	map_pair_a: assert property (pin_one_is_sec_enable |-> pin_two_is_power_good)
		else $error("illegal pin pairing");
	gain_range_a: assert property (in_range(vout_readback_gain_cal) && in_range(vin_readback_gain_cal) && in_range(iout_gain_cal))
		else $error("gain outside range");
	ofs_exp_a: assert property ({vout_readback_offset_cal[15:11], vin_readback_offset_cal[15:11], iout_offset_cal[15:11]} == {5'h14, 5'h1d, 5'h1c})
		else $error("offset exponent wrong");
	lock_hold_a: assert property ($past(write_protect_enable) |-> $stable(cal))
		else $error("calibration changed while locked");
	commit_idle_a: assert property ($changed({cal, write_protect_enable}) |-> scl_in && sda_in)
		else $error("register changed during a frame");
	sda_stand_a: assert property ($rose(sda_oe) |=> sda_oe [*3])
		else $error("data bit too short");
	sda_move_a: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data changed while clock high");
	cover property (ara_active);
	cover property ($fell(write_protect_enable));
	cover property (pin_two_is_sec_enable);
endmodule // pmbcfg_chk

bind pmbcfg_bank pmbcfg_chk pmbcfg_chk_i (.clk, .rst_b, .scl_in, .sda_in, .sda_oe,
	.alert_asserted, .ara_active, .write_protect_enable, .vout_readback_gain_cal,
	.vin_readback_gain_cal, .iout_gain_cal, .vout_readback_offset_cal,
	.vin_readback_offset_cal, .iout_offset_cal, .pin_one_is_trim,
	.pin_one_is_sec_enable, .pin_two_is_power_good, .pin_two_is_sec_enable);

/* tb/pmbcfg_host.sv */
`timescale 1ns/1ps
module pmbcfg_host (
	// Clock
	input wire clk,
	// Bus lines
	output logic scl,
	output logic sda_low,
	input wire sda
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Phases of 8 cycles, twice the device minimum, so sync delay never blurs an edge.
	task hold;
		repeat (8) @(posedge clk);
	endtask
	// SDA moves 2 cycles after SCL falls, so no edge of both lines coincides.
	task start;
		repeat (2) @(posedge clk);
		sda_low <= 1'b0;
		hold;
		scl <= 1'b1;
		hold;
		sda_low <= 1'b1;
		hold;
		scl <= 1'b0;
	endtask
	task stop;
		repeat (2) @(posedge clk);
		sda_low <= 1'b1;
		hold;
		scl <= 1'b1;
		hold;
		sda_low <= 1'b0;
		hold;
	endtask
	task bit_io(input b, output r);
		repeat (2) @(posedge clk);
		sda_low <= !b;
		hold;
		scl <= 1'b1;
		hold;
		r = sda;
		scl <= 1'b0;
	endtask
	task xfer(input [7:0] d, input ab, output [7:0] r, output rb);
		for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
		bit_io(ab, rb);
	endtask
endmodule // pmbcfg_host

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic alert = 1'b0;
	logic [6:0] strap = 7'h5a;
	logic [15:0] mv [4] = '{16'h1234, 16'h2345, 16'h3456, 16'h4567};
	logic [7:0] rcmd [4] = '{8'h88, 8'h8b, 8'h8c, 8'h8d};
	logic [3:0] pm [4] = '{4'h6, 4'ha, 4'h9, 4'h9};
	// Address that the bus tasks talk to; the second unit sits at its own strap.
	logic [6:0] dev = 7'h5a;
	logic [15:0] v;
	logic [7:0] q;
	logic a;
	wire scl;
	wire host_low;
	wire sda_oe;
	wire sda_out;
	wire sda_oe_ls;
	wire sda_out_ls;
	wire [3:0] pins_ls;
	// Open drain with pull-up: high unless someone pulls.
	wire sda = !(host_low || (sda_oe && !sda_out) || (sda_oe_ls && !sda_out_ls));
	wire [3:0] pins;
	int errors = 0;
	int n_tests = 0;
	always #12.5 clk = !clk;
	pmbcfg_host pmbcfg_host_i (.clk(clk), .scl(scl), .sda_low(host_low), .sda(sda));
	pmbcfg_bank pmbcfg_bank_i (.clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .bus_addr_strap(strap),
		.alert_asserted(alert), .meas_vin(mv[0]), .meas_vout(mv[1]), .meas_iout(mv[2]),
		.meas_temp(mv[3]), .vout_readback_gain_cal(), .vout_readback_offset_cal(),
		.vin_readback_gain_cal(), .vin_readback_offset_cal(), .iout_gain_cal(),
		.iout_offset_cal(), .write_protect_enable(), .ara_active(),
		.pin_one_is_trim(pins[3]), .pin_one_is_sec_enable(pins[2]),
		.pin_two_is_power_good(pins[1]), .pin_two_is_sec_enable(pins[0]));
	// Second unit built as the load-sharing variant, so its narrower pin map is exercised.
	pmbcfg_bank #(.LOAD_SHARE(1)) pmbcfg_bank_ls_i (.clk(clk), .rst_b(rst_b), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out_ls), .sda_oe(sda_oe_ls), .bus_addr_strap(7'h3c),
		.alert_asserted(alert), .meas_vin(mv[0]), .meas_vout(mv[1]), .meas_iout(mv[2]),
		.meas_temp(mv[3]), .vout_readback_gain_cal(), .vout_readback_offset_cal(),
		.vin_readback_gain_cal(), .vin_readback_offset_cal(), .iout_gain_cal(),
		.iout_offset_cal(), .write_protect_enable(), .ara_active(),
		.pin_one_is_trim(pins_ls[3]), .pin_one_is_sec_enable(pins_ls[2]),
		.pin_two_is_power_good(pins_ls[1]), .pin_two_is_sec_enable(pins_ls[0]));
	task chk(input [15:0] g, input [15:0] e);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	function automatic [7:0] crc(input [7:0] c, input [7:0] b);
		crc = c ^ b;
		for (int i = 0; i < 8; i++) crc = {crc[6:0], 1'b0} ^ (crc[7] ? 8'h07 : 8'h00);
	endfunction
	// p: 0 no check byte, 1 good one, 2 corrupted one.
	task wr(input [7:0] c, input [15:0] d, input int n, input int p);
		logic [7:0] k;
		k = crc(crc(8'h00, {dev, 1'b0}), c);
		pmbcfg_host_i.start;
		pmbcfg_host_i.xfer({dev, 1'b0}, 1'b1, q, a);
		pmbcfg_host_i.xfer(c, 1'b1, q, a);
		for (int i = 0; i < n; i++) begin
			pmbcfg_host_i.xfer(d[8*i+:8], 1'b1, q, a);
			k = crc(k, d[8*i+:8]);
		end
		if (p > 0) pmbcfg_host_i.xfer(k ^ 8'(p - 1), 1'b1, q, a);
		pmbcfg_host_i.stop;
	endtask
	task rc(input [7:0] c, input int n, input [15:0] e);
		v = 16'h0000;
		pmbcfg_host_i.start;
		pmbcfg_host_i.xfer({dev, 1'b0}, 1'b1, q, a);
		pmbcfg_host_i.xfer(c, 1'b1, q, a);
		pmbcfg_host_i.start;
		pmbcfg_host_i.xfer({dev, 1'b1}, 1'b1, q, a);
		for (int i = 0; i < n; i++) begin
			pmbcfg_host_i.xfer(8'hff, i == n - 1, q, a);
			v[8*i+:8] = q;
		end
		pmbcfg_host_i.stop;
		chk(v, e);
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#2400000;
		errors++;
		tally_and_finish;
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		rc(8'h7e, 1, 16'h0000);
		rc(8'hd0, 2, 16'h00aa);
		rc(8'hd1, 2, 16'h2000);
		rc(8'hd3, 2, 16'h2000);
		rc(8'hd2, 2, 16'ha000);
		rc(8'hd4, 2, 16'he800);
		rc(8'hdb, 1, 16'h0010);
		rc(8'he0, 1, 16'h0000);
		$display("test reset done");
		for (int k = 0; k < 2; k++)
			for (int i = 0; i < 4; i++) begin
				rc(rcmd[i], 2, mv[i]);
				mv[i] <= ~mv[i];
			end
		$display("test readback done");
		wr(8'hd1, 16'h2100, 2, 0);
		rc(8'hd1, 2, 16'h2000);
		rc(8'h7e, 1, 16'h0040);
		wr(8'h7e, 16'h0040, 1, 0);
		rc(8'h7e, 1, 16'h0000);
		wr(8'hd0, 16'h00a8, 2, 0);
		rc(8'hd0, 2, 16'h00a8);
		$display("test lock done");
		wr(8'hd1, 16'h2666, 2, 1);
		wr(8'hd3, 16'h1999, 2, 0);
		wr(8'hd6, 16'h1998, 2, 0);
		wr(8'hd2, 16'ha123, 2, 0);
		wr(8'hd4, 16'he805, 2, 0);
		wr(8'hd7, 16'he00f, 2, 0);
		rc(8'hd1, 2, 16'h2666);
		rc(8'hd3, 2, 16'h1999);
		rc(8'hd6, 2, 16'h2000);
		rc(8'hd2, 2, 16'ha123);
		rc(8'hd4, 2, 16'he805);
		rc(8'hd7, 2, 16'he00f);
		$display("test calibration done");
		wr(8'hd2, 16'ha800, 2, 0);
		wr(8'hc0, 16'h0000, 0, 0);
		wr(8'hd1, 16'h2000, 2, 2);
		rc(8'hd2, 2, 16'ha123);
		rc(8'h7e, 1, 16'h00e0);
		rc(8'hd1, 2, 16'h2666);
		rc(8'h7e, 1, 16'h00e0);
		wr(8'h7e, 16'h0020, 1, 0);
		rc(8'h7e, 1, 16'h00c0);
		wr(8'h7e, 16'h00c0, 1, 0);
		rc(8'h7e, 1, 16'h0000);
		wr(8'hd0, 16'h00aa, 2, 0);
		wr(8'hd7, 16'he001, 2, 0);
		rc(8'hd7, 2, 16'he00f);
		wr(8'hdb, 16'h0055, 1, 0);
		rc(8'hdb, 1, 16'h0010);
		rc(8'h7e, 1, 16'h00c0);
		$display("test faults done");
		// A reset in mid-run must bring back the defaults of 0xd1, 0x7e, 0xd0 and 0xe0.
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		rc(8'hd1, 2, 16'h2000);
		rc(8'h7e, 1, 16'h0000);
		rc(8'hd0, 2, 16'h00aa);
		rc(8'he0, 1, 16'h0000);
		$display("test second reset done");
		for (int m = 0; m < 4; m++) begin
			wr(8'he0, 16'(m), 1, 0);
			chk(16'(pins), 16'(pm[m]));
		end
		$display("test pins done");
		dev = 7'h3c;
		wr(8'he0, 16'h0001, 1, 0);
		chk(16'(pins_ls), 16'h0006);
		rc(8'he0, 1, 16'h0000);
		rc(8'h7e, 1, 16'h0040);
		dev = strap;
		$display("test load share done");
		alert <= 1'b1;
		rc(8'hdb, 1, 16'h0010);
		wr(8'he0, 16'h0010, 1, 0);
		pmbcfg_host_i.start;
		pmbcfg_host_i.xfer({strap, 1'b0}, 1'b1, q, a);
		pmbcfg_host_i.stop;
		chk(16'(a), 16'h0001);
		pmbcfg_host_i.start;
		pmbcfg_host_i.xfer(8'h19, 1'b1, q, a);
		pmbcfg_host_i.xfer(8'hff, 1'b1, q, a);
		pmbcfg_host_i.stop;
		chk(16'(q), 16'({strap, 1'b0}));
		alert <= 1'b0;
		rc(8'he0, 1, 16'h0010);
		$display("test alert done");
		tally_and_finish;
	end
endmodule // tb
